//--- hdl/rofm_pkg.sv
// package: offsets, reset values, field positions and carriers for the rail override/fault mask bank
package rofm_pkg;
   // register offsets on the i2c target register space
   localparam logic [7:0] OFS_RAIL_DISABLE_CTRL   = 8'h9f;
   localparam logic [7:0] OFS_RAIL_OVERRIDE_ONE   = 8'ha0;
   localparam logic [7:0] OFS_RAIL_OVERRIDE_TWO   = 8'ha1;
   localparam logic [7:0] OFS_RAIL_FAULT_MASK_ONE = 8'ha2;

   // reset values
   localparam logic [7:0] RST_RAIL_DISABLE_CTRL   = 8'he0;
   localparam logic [7:0] RST_RAIL_OVERRIDE_ONE   = 8'h80;
   localparam logic [7:0] RST_RAIL_OVERRIDE_TWO   = 8'h89;
   localparam logic [7:0] RST_RAIL_FAULT_MASK_ONE = 8'hc0;

   // rail_disable_ctrl fields
   localparam int BIT_SWITCH_B2_FORCE_OFF   = 7;
   localparam int BIT_SWITCH_B1_FORCE_OFF   = 6;
   localparam int BIT_SWITCH_A1_FORCE_OFF   = 5;
   localparam int BIT_TERMINATION_FORCE_OFF = 4;
   localparam logic [7:0] DIS_RESERVED_MASK = 8'h0f;

   // override one / fault mask one fields (same layout)
   localparam int BIT_LINEAR_A2     = 7;
   localparam int BIT_SWITCH_A1     = 6;
   localparam int STEPDOWN_COUNT    = 6;

   // override two fields
   localparam int BIT_OUTPUT_4_LEVEL     = 7;
   localparam int BIT_OUTPUT_1_LEVEL     = 4;
   localparam int BIT_TERMINATION_ON     = 3;
   localparam int BIT_SWITCH_B2_ON       = 2;
   localparam int BIT_SWITCH_B1_ON       = 1;
   localparam int BIT_LINEAR_A3_ON       = 0;

   // stepdown 1..3 force-off bits in the separate control register
   localparam int STEPDOWN_DIS_EXT_COUNT = 3;

   localparam int RAIL_COUNT = 12;
   // rail index order used on the rail vectors
   localparam int R_SD1 = 0;
   localparam int R_LA2 = 6;
   localparam int R_SA1 = 7;
   localparam int R_SB1 = 8;
   localparam int R_SB2 = 9;
   localparam int R_TRM = 10;
   localparam int R_LA3 = 11;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rofm_reg_req_s;

   typedef struct packed {
      logic       hit;
      logic [7:0] rdata;
   } rofm_reg_rsp_s;
endpackage

//--- hdl/rofm_regs.sv
// rail disable / enable override / gpo level / fault mask register bank
`timescale 1ns/1ps
module rofm_regs #(
   parameter int NUM_GPO = 4
) (
   // clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       clk_en_i,
   // register port from the i2c target engine
   input  wire rofm_pkg::rofm_reg_req_s    reg_req_i,
   output      rofm_pkg::rofm_reg_rsp_s    reg_rsp_o,
   // rail control inputs: pin/pg request per rail, stepdown 1..3 force-off bits
   input  wire logic [11:0]                rail_pin_req_i,
   input  wire logic [2:0]                 stepdown_force_off_i,
   input  wire logic [11:0]                rail_fault_i,
   // factory configuration of the gp outputs
   input  wire logic [NUM_GPO-1:0]         gpo_is_gp_output_i,
   input  wire logic [NUM_GPO-1:0]         gpo_push_pull_i,
   // rail enables and shutdown request
   output      logic [11:0]                rail_enable_o,
   output      logic                       shutdown_req_o,
   // gp output pins: level out and output enable (low = driving)
   output      logic [NUM_GPO-1:0]         gpo_o,
   output      logic [NUM_GPO-1:0]         gpo_oe_n_o
);
   // the level mapping below serves exactly the four gp pins behind override two
   if (NUM_GPO != 4) begin : g_bad_gpo_count
      $error("rofm_regs: NUM_GPO must be 4");
   end
   // the external stepdown force-off bits must land on stepdown rails
   if (rofm_pkg::STEPDOWN_DIS_EXT_COUNT > rofm_pkg::STEPDOWN_COUNT) begin : g_bad_stepdown_count
      $error("rofm_regs: more external force-off bits than stepdown rails");
   end

   // register images
   logic [7:0]  dis_r;
   logic [7:0]  ovr1_r;
   logic [7:0]  ovr2_r;
   logic [7:0]  fmask_r;

   // per-rail views of the register bits
   logic [11:0] rail_override;
   logic [11:0] rail_permit;
   logic [11:0] rail_fmask;
   logic [11:0] rail_want;
   logic [11:0] fault_live;

   // one write strobe per register; a write while the enable is low is dropped
   logic        wr_dis;
   logic        wr_ovr1;
   logic        wr_ovr2;
   logic        wr_fmask;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic wr_to(input rofm_pkg::rofm_reg_req_s r, input logic en, input logic [7:0] ofs);
      return en && r.wr && addr_is(r.addr, ofs);
   endfunction

   // write decode, shared by the four register processes
   always_comb begin
      wr_dis   = wr_to(reg_req_i, clk_en_i, rofm_pkg::OFS_RAIL_DISABLE_CTRL);
      wr_ovr1  = wr_to(reg_req_i, clk_en_i, rofm_pkg::OFS_RAIL_OVERRIDE_ONE);
      wr_ovr2  = wr_to(reg_req_i, clk_en_i, rofm_pkg::OFS_RAIL_OVERRIDE_TWO);
      wr_fmask = wr_to(reg_req_i, clk_en_i, rofm_pkg::OFS_RAIL_FAULT_MASK_ONE);
   end

   // rail disable: switches permitted, termination held off after reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dis_r <= rofm_pkg::RST_RAIL_DISABLE_CTRL;
      end else if (wr_dis) begin
         // reserved bits stored as written; the host keeps them zero
         dis_r <= reg_req_i.wdata;
      end
   end

   // override one: only linear a2 forced on after reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ovr1_r <= rofm_pkg::RST_RAIL_OVERRIDE_ONE;
      end else if (wr_ovr1) begin
         ovr1_r <= reg_req_i.wdata;
      end
   end

   // override two and gp levels: termination, a3 and gp_output_4 high after reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ovr2_r <= rofm_pkg::RST_RAIL_OVERRIDE_TWO;
      end else if (wr_ovr2) begin
         ovr2_r <= reg_req_i.wdata;
      end
   end

   // fault mask one: linear a2 and switch a1 masked after reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fmask_r <= rofm_pkg::RST_RAIL_FAULT_MASK_ONE;
      end else if (wr_fmask) begin
         fmask_r <= reg_req_i.wdata;
      end
   end

   // read path, combinational so the engine sees data in the address cycle
   always_comb begin
      reg_rsp_o = '0;
      case (reg_req_i.addr)
         rofm_pkg::OFS_RAIL_DISABLE_CTRL: begin
            reg_rsp_o.hit   = 1'b1;
            reg_rsp_o.rdata = dis_r;
         end
         rofm_pkg::OFS_RAIL_OVERRIDE_ONE: begin
            reg_rsp_o.hit   = 1'b1;
            reg_rsp_o.rdata = ovr1_r;
         end
         rofm_pkg::OFS_RAIL_OVERRIDE_TWO: begin
            reg_rsp_o.hit   = 1'b1;
            reg_rsp_o.rdata = ovr2_r;
         end
         rofm_pkg::OFS_RAIL_FAULT_MASK_ONE: begin
            reg_rsp_o.hit   = 1'b1;
            reg_rsp_o.rdata = fmask_r;
         end
         default: begin
            // unmapped offsets answer with no hit and zero data
            reg_rsp_o = '0;
         end
      endcase
   end

   // map register bits onto the rail vector
   always_comb begin
      rail_override = '0;
      rail_fmask    = '0;
      rail_permit   = '1;
      rail_override[rofm_pkg::R_SD1 +: rofm_pkg::STEPDOWN_COUNT] = ovr1_r[5:0];
      rail_override[rofm_pkg::R_LA2] = ovr1_r[rofm_pkg::BIT_LINEAR_A2];
      rail_override[rofm_pkg::R_SA1] = ovr1_r[rofm_pkg::BIT_SWITCH_A1];
      rail_override[rofm_pkg::R_SB1] = ovr2_r[rofm_pkg::BIT_SWITCH_B1_ON];
      rail_override[rofm_pkg::R_SB2] = ovr2_r[rofm_pkg::BIT_SWITCH_B2_ON];
      rail_override[rofm_pkg::R_TRM] = ovr2_r[rofm_pkg::BIT_TERMINATION_ON];
      rail_override[rofm_pkg::R_LA3] = ovr2_r[rofm_pkg::BIT_LINEAR_A3_ON];
      rail_fmask[rofm_pkg::R_SD1 +: rofm_pkg::STEPDOWN_COUNT] = fmask_r[5:0];
      rail_fmask[rofm_pkg::R_LA2] = fmask_r[rofm_pkg::BIT_LINEAR_A2];
      rail_fmask[rofm_pkg::R_SA1] = fmask_r[rofm_pkg::BIT_SWITCH_A1];
      // switches b1/b2, termination and linear a3 have no mask bit here, so their faults always count
      rail_permit[rofm_pkg::R_SA1] = dis_r[rofm_pkg::BIT_SWITCH_A1_FORCE_OFF];
      rail_permit[rofm_pkg::R_SB1] = dis_r[rofm_pkg::BIT_SWITCH_B1_FORCE_OFF];
      rail_permit[rofm_pkg::R_SB2] = dis_r[rofm_pkg::BIT_SWITCH_B2_FORCE_OFF];
      rail_permit[rofm_pkg::R_TRM] = dis_r[rofm_pkg::BIT_TERMINATION_FORCE_OFF];
      // stepdown 1..3 keep their own disable bits outside this bank
      rail_permit[rofm_pkg::R_SD1 +: rofm_pkg::STEPDOWN_DIS_EXT_COUNT] = stepdown_force_off_i;
      // limitation: stepdown 4..6 and the linear rails have no force-off input here and stay permitted
      // a rail runs when permitted and either forced on or asked for by its pin
      rail_want  = rail_permit & (rail_override | rail_pin_req_i);
      // faults that still reach the shutdown request
      fault_live = rail_fault_i & ~rail_fmask;
   end

   // rail enables: disable beats override, override beats pin request
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rail_enable_o <= '0;
      end else if (clk_en_i) begin
         rail_enable_o <= rail_want;
      end
   end

   // shutdown request from any unmasked fault
   // the request only reports; ramping the rails down is left to the sequencer outside
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         shutdown_req_o <= 1'b0;
      end else if (clk_en_i) begin
         shutdown_req_o <= |fault_live;
      end
   end

   // gp outputs: gpo 4 is open-drain only, gpo 1..3 may be push-pull
   for (genvar g = 0; g < NUM_GPO; g++) begin : g_gpo
      localparam int LB      = rofm_pkg::BIT_OUTPUT_1_LEVEL + g;
      localparam bit OD_ONLY = (LB == rofm_pkg::BIT_OUTPUT_4_LEVEL);
      logic          level_r;
      logic          oe_n_r;

      always_ff @(posedge sys_clk_i) begin
         if (rst_i) begin
            level_r <= 1'b0;
            oe_n_r  <= 1'b1;
         end else if (clk_en_i) begin
            // pins not configured as gp outputs are released
            level_r <= 1'b0;
            oe_n_r  <= 1'b1;
            if (gpo_is_gp_output_i[g]) begin
               if (gpo_push_pull_i[g] && !OD_ONLY) begin
                  level_r <= ovr2_r[LB];
                  oe_n_r  <= 1'b0;
               end else begin
                  // open drain: drive only the low level, high is released
                  oe_n_r <= ovr2_r[LB];
               end
            end
         end
      end

      assign gpo_o[g]      = level_r;
      assign gpo_oe_n_o[g] = oe_n_r;
   end
endmodule // rofm_regs

//--- dv/rofm_regs_properties.sv
// concurrent checks on the rail override and fault mask bank ports
`timescale 1ns/1ps
module rofm_regs_properties #(parameter int NUM_GPO = 4) (
   input wire logic                    sys_clk_i,
   input wire logic                    rst_i,
   input wire logic                    clk_en_i,
   input wire rofm_pkg::rofm_reg_req_s reg_req_i,
   input wire rofm_pkg::rofm_reg_rsp_s reg_rsp_o,
   input wire logic [11:0]             rail_pin_req_i,
   input wire logic [2:0]              stepdown_force_off_i,
   input wire logic [11:0]             rail_fault_i,
   input wire logic [NUM_GPO-1:0]      gpo_is_gp_output_i,
   input wire logic [NUM_GPO-1:0]      gpo_push_pull_i,
   input wire logic [11:0]             rail_enable_o,
   input wire logic                    shutdown_req_o,
   input wire logic [NUM_GPO-1:0]      gpo_o,
   input wire logic [NUM_GPO-1:0]      gpo_oe_n_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence wr_s;
      clk_en_i && reg_req_i.wr && reg_rsp_o.hit;
   endsequence
   unmapped_read_a: assert property ((reg_req_i.addr < 8'h9f || reg_req_i.addr > 8'ha2) |-> reg_rsp_o == '0)
      else $error("unmapped read not zero");
   mapped_hit_a: assert property (reg_req_i.addr inside {[8'h9f:8'ha2]} |-> reg_rsp_o.hit)
      else $error("mapped address missed");
   write_readback_a: assert property (wr_s |=> reg_req_i.addr != $past(reg_req_i.addr) || reg_rsp_o.rdata == $past(reg_req_i.wdata))
      else $error("write not read back");
   fault_quiet_a: assert property (clk_en_i && rail_fault_i == '0 |=> !shutdown_req_o)
      else $error("shutdown without fault");
   fault_unmasked_a: assert property (clk_en_i && |rail_fault_i[11:8] |=> shutdown_req_o)
      else $error("unmasked fault ignored");
   pin_follow_a: assert property (clk_en_i && &rail_pin_req_i[5:3] |=> &rail_enable_o[5:3])
      else $error("pin request not followed");
   stepdown_off_a: assert property (clk_en_i && !stepdown_force_off_i[0] |=> !rail_enable_o[0])
      else $error("stepdown force off lost");
   output_four_a: assert property (clk_en_i |=> !gpo_o[3])
      else $error("open drain output drives high");
   output_release_a: assert property (clk_en_i && !gpo_is_gp_output_i[0] |=> gpo_oe_n_o[0])
      else $error("non gp pin driven");
endmodule // rofm_regs_properties

bind rofm_regs rofm_regs_properties #(.NUM_GPO(NUM_GPO)) i_props (.sys_clk_i, .rst_i, .clk_en_i, .reg_req_i,
   .reg_rsp_o, .rail_pin_req_i, .stepdown_force_off_i, .rail_fault_i, .gpo_is_gp_output_i, .gpo_push_pull_i,
   .rail_enable_o, .shutdown_req_o, .gpo_o, .gpo_oe_n_o);

//--- dv/rofm_host_model.sv
// host model: register writes and reads, driven on the falling edge
`timescale 1ns/1ps
module rofm_host_model (
   input  wire logic                    sys_clk_i,
   input  wire rofm_pkg::rofm_reg_rsp_s rsp_i,
   output rofm_pkg::rofm_reg_req_s      req_o
);
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      req_o = '{1'b1, a, (a == rofm_pkg::OFS_RAIL_DISABLE_CTRL) ? d & ~rofm_pkg::DIS_RESERVED_MASK : d};
      @(negedge sys_clk_i);
      req_o.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output rofm_pkg::rofm_reg_rsp_s r);
      @(negedge sys_clk_i);
      req_o = '{1'b0, a, 8'h00};
      @(posedge sys_clk_i);
      r = rsp_i;
      @(negedge sys_clk_i);
   endtask
endmodule // rofm_host_model

//--- dv/rofm_regs_tb.sv
// self-checking bench for the rail override and fault mask bank
`timescale 1ns/1ps
module rofm_regs_tb;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, sd_req;
   logic [11:0] pin_req = '0, fault = '0, rail_en;
   logic [2:0] sd_off = 3'h7;
   logic [3:0] gp_cfg = 4'he, pp_cfg = 4'h1, gpo, gpo_oe_n;
   rofm_pkg::rofm_reg_req_s req;
   rofm_pkg::rofm_reg_rsp_s rsp;
   int n_fail = 0, total_checks = 0;
   logic [7:0] rst_tbl [4] = '{8'he0, 8'h80, 8'h89, 8'hc0};
   rofm_host_model i_host (.sys_clk_i, .rsp_i(rsp), .req_o(req));
   rofm_regs #(.NUM_GPO(4)) i_dut (.sys_clk_i, .rst_i, .clk_en_i, .reg_req_i(req), .reg_rsp_o(rsp),
      .rail_pin_req_i(pin_req), .stepdown_force_off_i(sd_off), .rail_fault_i(fault), .gpo_is_gp_output_i(gp_cfg),
      .gpo_push_pull_i(pp_cfg), .rail_enable_o(rail_en), .shutdown_req_o(sd_req), .gpo_o(gpo), .gpo_oe_n_o(gpo_oe_n));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [8:0] exp);
      rofm_pkg::rofm_reg_rsp_s r;
      i_host.rd(a, r);
      chk(24'(r), 24'(exp));
   endtask
   // outputs lag their cause by one enabled edge
   task automatic settle;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 4; i++) rdc(8'h9f + 8'(i), {1'b1, rst_tbl[i]});
      rdc(8'h9e, 9'h0);
      rdc(8'ha3, 9'h0);
      settle;
      chk({rail_en, sd_req, gpo, gpo_oe_n}, {12'h840, 1'b0, 4'h0, 4'h9});
      i_host.wr(8'h9f, 8'hf0);
      settle;
      chk(rail_en, 12'hc40);
      pin_req = '1;
      i_host.wr(8'h9f, 8'h00);
      settle;
      chk(rail_en, 12'h87f);
      sd_off = 3'h0;
      settle;
      chk(rail_en, 12'h878);
      pin_req = '0;
      i_host.wr(8'ha0, 8'h3f);
      settle;
      chk(rail_en, 12'h838);
      clk_en_i = 1'b0;
      i_host.wr(8'ha0, 8'h00);
      clk_en_i = 1'b1;
      rdc(8'ha0, 9'h13f);
      fault = 12'h040;
      settle;
      chk(sd_req, 1'b0);
      fault = 12'h001;
      settle;
      chk(sd_req, 1'b1);
      i_host.wr(8'ha2, 8'hc1);
      settle;
      chk(sd_req, 1'b0);
      fault = 12'h100;
      settle;
      chk(sd_req, 1'b1);
      gp_cfg = 4'hf;
      i_host.wr(8'ha1, 8'h39);
      settle;
      chk({gpo, gpo_oe_n}, 8'h12);
      rdc(8'ha1, 9'h139);
      // outputs hold while the clock enable is low
      clk_en_i = 1'b0;
      pin_req  = '1;
      fault    = '0;
      settle;
      chk({rail_en, sd_req}, {12'h838, 1'b1});
      clk_en_i = 1'b1;
      settle;
      chk({rail_en, sd_req}, {12'h878, 1'b0});
      // second reset in mid-run; gp_output_4 stays open drain even when flagged push-pull
      rst_i  = 1'b1;
      pp_cfg = 4'h9;
      settle;
      chk({rail_en, sd_req, gpo, gpo_oe_n}, {12'h000, 1'b0, 4'h0, 4'hf});
      rst_i = 1'b0;
      for (int i = 0; i < 4; i++) rdc(8'h9f + 8'(i), {1'b1, rst_tbl[i]});
      settle;
      chk({rail_en, sd_req, gpo, gpo_oe_n}, {12'hbf8, 1'b0, 4'h0, 4'h8});
      stop_test();
   end
endmodule // rofm_regs_tb
